//--- hdl/anpr_regs_top.v
/*
 * Auto-negotiation expansion status, next-page transmit and partner
 * next-page registers behind a serial management slave (clock and
 * bidirectional data pin, preamble, start, opcode, addresses,
 * turnaround, 16 data bits).
 * Assumes the negotiation engine runs on mclk and drives the event and
 * page inputs; mdc, mdio and the address strap come from pins.
 */
//
// Function
// - Parallel-detection fault (bit 4) and page received (bit 1) of the expansion register latch at one until read and reset to zero.
// - Expansion bit 3 shows partner next-page ability and bit 0 partner auto-negotiation ability, both live from lp_np_able and lp_an_able with no reset.
// - Expansion bit 2 reads one for local next-page ability and bits 15 to 5 always read zero.
// - Next-page transmit bits 15, 13 and 12 are writable with reset values 0, 1 and 0.
// - Next-page transmit bit 11 is read-only and shows the last sent toggle live from tx_toggle with no reset, and bit 14 reads zero.
// - Next-page transmit bits 10 to 0 are a writable code field resetting to one in bit 0 only.
// - Partner next-page register captures more-pages, message, comply and code fields read-only, bit 14 zero, reset zero.
// - Partner next-page bit 11 shows the received toggle read-only and resets to zero.
`timescale 1ns/1ps
`default_nettype none
`include "anpr_regs.vh"

module anpr_regs_top (
    input wire mclk,
    input wire reset,
    input wire mdc,
    input wire mdio_in,
    output reg mdio_out,
    output reg mdio_oe_n,
    input wire [4:0] phy_addr,
    input wire pd_fault_evt,
    input wire page_rx_evt,
    input wire lp_np_able,
    input wire lp_an_able,
    input wire tx_toggle,
    input wire lp_page_load,
    input wire [15:0] lp_page,
    output reg [15:0] np_tx_word_q,
    output reg np_tx_written_q
);

    // ------------------------------------------------------------------
    // Frame states
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_OP = 3'h2;
    localparam [2:0] ST_ADDR = 3'h3;
    localparam [2:0] ST_TA = 3'h4;
    localparam [2:0] ST_DATA = 3'h5;

    // Reset image of the transmit page, so each field is cut at its own width
    localparam [15:0] NP_TX_RST = `ANPR_NP_TX_RESET;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg mdc_s1_q, mdc_s2_q, mdc_s3_q;
    reg mdio_s1_q, mdio_s2_q;
    reg [4:0] padr_s1_q, padr_s2_q;
    wire mdc_rise;
    wire bit_in;

    always @(posedge mclk) begin
        if (reset) begin
            mdc_s1_q <= 1'b0;
            mdc_s2_q <= 1'b0;
            mdc_s3_q <= 1'b0;
            mdio_s1_q <= 1'b1;
            mdio_s2_q <= 1'b1;
            padr_s1_q <= 5'h00;
            padr_s2_q <= 5'h00;
        end else begin
            mdc_s1_q <= mdc;
            mdc_s2_q <= mdc_s1_q;
            mdc_s3_q <= mdc_s2_q;
            mdio_s1_q <= mdio_in;
            mdio_s2_q <= mdio_s1_q;
            padr_s1_q <= phy_addr;
            padr_s2_q <= padr_s1_q;
        end
    end

    // Data and clock share synchroniser depth, so the sample stays aligned
    assign mdc_rise = mdc_s2_q & ~mdc_s3_q;
    assign bit_in = mdio_s2_q;

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    reg np_more_q, np_msg_q, np_ack2_q;
    reg [10:0] np_code_q;
    reg [15:0] lp_np_q;
    wire pdf_stat, page_rx_stat;
    reg exp_rd_clr;
    reg wr_np_tx;
    reg [15:0] wr_data;
    wire [15:0] exp_word;
    wire [15:0] np_tx_word;

    anpr_lh_bit u_pdf (
        .mclk(mclk),
        .reset(reset),
        .set_evt(pd_fault_evt),
        .rd_clr(exp_rd_clr),
        .stat_q(pdf_stat)
    );

    anpr_lh_bit u_page_rx (
        .mclk(mclk),
        .reset(reset),
        .set_evt(page_rx_evt),
        .rd_clr(exp_rd_clr),
        .stat_q(page_rx_stat)
    );

    // Upper bits are constant zero
    assign exp_word = {11'h000, pdf_stat, lp_np_able, `ANPR_LOCAL_NP_ABLE,
                       page_rx_stat, lp_an_able};

    // Toggle follows the engine; reserved bit fixed at zero
    assign np_tx_word = {np_more_q, 1'b0, np_msg_q, np_ack2_q, tx_toggle, np_code_q};

    always @(posedge mclk) begin
        if (reset) begin
            np_more_q <= NP_TX_RST[`ANPR_NP_MORE_BIT];
            np_msg_q <= NP_TX_RST[`ANPR_NP_MSG_BIT];
            np_ack2_q <= NP_TX_RST[`ANPR_NP_ACK2_BIT];
            np_code_q <= NP_TX_RST[`ANPR_NP_CODE_MSB:0];
            np_tx_word_q <= NP_TX_RST;
            np_tx_written_q <= 1'b0;
            lp_np_q <= `ANPR_LP_NP_RESET;
        end else begin
            if (wr_np_tx) begin
                // Bits 14 and 11 are dropped on write
                np_more_q <= wr_data[`ANPR_NP_MORE_BIT];
                np_msg_q <= wr_data[`ANPR_NP_MSG_BIT];
                np_ack2_q <= wr_data[`ANPR_NP_ACK2_BIT];
                np_code_q <= wr_data[`ANPR_NP_CODE_MSB:0];
            end
            np_tx_word_q <= np_tx_word;
            np_tx_written_q <= wr_np_tx;
            if (lp_page_load) begin
                lp_np_q <= {lp_page[15], 1'b0, lp_page[13:0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Management frame engine
    // ------------------------------------------------------------------
    reg [2:0] state_q;
    reg [4:0] cnt_q;
    reg seen_one_q;
    reg [1:0] op_q;
    reg [9:0] addr_q;
    reg [15:0] shift_q;
    reg rd_go_q;
    reg wr_go_q;
    reg [15:0] rd_word;
    wire [9:0] addr_next;
    wire [15:0] shift_next;

    assign addr_next = {addr_q[8:0], bit_in};
    assign shift_next = {shift_q[14:0], bit_in};

    // Unmapped register addresses read as zero
    always @* begin
        case (addr_q[4:0])
            `ANPR_ADDR_EXP_STATUS: rd_word = exp_word;
            `ANPR_ADDR_NP_TX: rd_word = np_tx_word;
            `ANPR_ADDR_LP_NP_RX: rd_word = lp_np_q;
            default: rd_word = 16'h0000;
        endcase
    end

    always @* begin
        exp_rd_clr = 1'b0;
        wr_np_tx = 1'b0;
        wr_data = shift_next;
        if (mdc_rise && state_q == ST_TA && cnt_q == 5'h00 && rd_go_q) begin
            // Clear only when the snapshot is taken
            exp_rd_clr = (addr_q[4:0] == `ANPR_ADDR_EXP_STATUS);
        end
        if (mdc_rise && state_q == ST_DATA && wr_go_q && cnt_q == `ANPR_DATA_BITS - 5'h01) begin
            wr_np_tx = (addr_q[4:0] == `ANPR_ADDR_NP_TX);
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            state_q <= ST_IDLE;
            cnt_q <= 5'h00;
            seen_one_q <= 1'b0;
            op_q <= 2'h0;
            addr_q <= 10'h000;
            shift_q <= 16'h0000;
            rd_go_q <= 1'b0;
            wr_go_q <= 1'b0;
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
        end else if (mdc_rise) begin
            case (state_q)
                ST_IDLE: begin
                    if (bit_in) begin
                        seen_one_q <= 1'b1;
                    end else if (seen_one_q) begin
                        state_q <= ST_START;
                    end
                end
                ST_START: begin
                    seen_one_q <= 1'b0;
                    cnt_q <= 5'h00;
                    state_q <= bit_in ? ST_OP : ST_IDLE;
                end
                ST_OP: begin
                    op_q <= {op_q[0], bit_in};
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h01) begin
                        cnt_q <= 5'h00;
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    addr_q <= addr_next;
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == {1'b0, `ANPR_ADDR_BITS} - 5'h01) begin
                        cnt_q <= 5'h00;
                        rd_go_q <= (op_q == `ANPR_OP_READ) && (addr_next[9:5] == padr_s2_q);
                        wr_go_q <= (op_q == `ANPR_OP_WRITE) && (addr_next[9:5] == padr_s2_q);
                        state_q <= ST_TA;
                    end
                end
                ST_TA: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h00) begin
                        if (rd_go_q) begin
                            // Second turnaround bit driven low
                            mdio_out <= 1'b0;
                            mdio_oe_n <= 1'b0;
                            shift_q <= rd_word;
                        end
                    end else begin
                        cnt_q <= 5'h00;
                        state_q <= ST_DATA;
                        if (rd_go_q) begin
                            mdio_out <= shift_q[15];
                            shift_q <= {shift_q[14:0], 1'b0};
                        end
                    end
                end
                ST_DATA: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (rd_go_q) begin
                        mdio_out <= shift_q[15];
                        shift_q <= {shift_q[14:0], 1'b0};
                    end else begin
                        shift_q <= shift_next;
                    end
                    if (cnt_q == `ANPR_DATA_BITS - 5'h01) begin
                        // Release the pin after the last data bit
                        mdio_out <= 1'b1;
                        mdio_oe_n <= 1'b1;
                        rd_go_q <= 1'b0;
                        wr_go_q <= 1'b0;
                        cnt_q <= 5'h00;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // anpr_regs_top

`default_nettype wire

//--- hdl/anpr_regs.vh
/*
 * Register map, field positions and reset values of the auto-negotiation
 * expansion and next-page register group.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ANPR_REGS_VH
`define ANPR_REGS_VH

// ----------------------------------------------------------------------
// Register addresses on the management bus
// ----------------------------------------------------------------------
`define ANPR_ADDR_EXP_STATUS 5'h06
`define ANPR_ADDR_NP_TX 5'h07
`define ANPR_ADDR_LP_NP_RX 5'h08

// ----------------------------------------------------------------------
// Expansion status fields
// ----------------------------------------------------------------------
`define ANPR_EXP_PDF_BIT 4
`define ANPR_EXP_LP_NP_ABLE_BIT 3
`define ANPR_EXP_NP_ABLE_BIT 2
`define ANPR_EXP_PAGE_RX_BIT 1
`define ANPR_EXP_LP_AN_ABLE_BIT 0
`define ANPR_EXP_RESET 16'h0004
`define ANPR_LOCAL_NP_ABLE 1'b1

// ----------------------------------------------------------------------
// Next-page word fields (transmit and partner receive)
// ----------------------------------------------------------------------
`define ANPR_NP_MORE_BIT 15
`define ANPR_NP_RSVD_BIT 14
`define ANPR_NP_MSG_BIT 13
`define ANPR_NP_ACK2_BIT 12
`define ANPR_NP_TOGGLE_BIT 11
`define ANPR_NP_CODE_MSB 10
`define ANPR_NP_TX_RESET 16'h2001
`define ANPR_NP_TX_CODE_RESET 11'h001
`define ANPR_LP_NP_RESET 16'h0000

// ----------------------------------------------------------------------
// Management frame codes
// ----------------------------------------------------------------------
`define ANPR_OP_READ 2'h2
`define ANPR_OP_WRITE 2'h1
`define ANPR_ADDR_BITS 4'ha
`define ANPR_DATA_BITS 5'h10

`endif

//--- hdl/anpr_lh_bit.v
/*
 * One status bit that latches high on an event and clears when read.
 * Assumes event and read-clear are pulses on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module anpr_lh_bit (
    input wire mclk,
    input wire reset,
    input wire set_evt,
    input wire rd_clr,
    output reg stat_q
);

    wire stat_d;

    // Set beats clear so an event during the read is not lost
    assign stat_d = set_evt | (stat_q & ~rd_clr);

    always @(posedge mclk) begin
        if (reset) begin
            stat_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
        end
    end

endmodule // anpr_lh_bit

`default_nettype wire

//--- sim/anpr_regs_checker.sv
/* Assertions on the register group's top ports.
   Assumes one mclk domain with synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module anpr_regs_checker (
    input wire logic mclk,
    input wire logic reset,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    input wire logic tx_toggle,
    input wire logic [15:0] np_tx_word_q,
    input wire logic np_tx_written_q
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // Turnaround zero lasts half an mdc period at least
    sequence turn_s; (!mdio_oe_n && !mdio_out) [*8]; endsequence
    chk_tx_reset: assert property ($fell(reset) |-> (np_tx_word_q & 16'hf7ff) == 16'h2001)
        else $error("tx word off reset value");
    chk_toggle_live: assert property (np_tx_word_q[11] == $past(tx_toggle))
        else $error("tx toggle not followed");
    chk_tx_rsvd: assert property (np_tx_word_q[14] == 1'b0)
        else $error("tx reserved bit set");
    chk_word_steady: assert property ($changed(np_tx_word_q & 16'hf7ff) |-> $past(np_tx_written_q))
        else $error("tx word changed without write");
    chk_write_pulse: assert property (np_tx_written_q |=> !np_tx_written_q)
        else $error("write pulse too long");
    chk_read_turn: assert property ($fell(mdio_oe_n) |-> turn_s)
        else $error("read turnaround wrong");
    chk_idle_high: assert property (mdio_oe_n |-> mdio_out)
        else $error("released data not high");
    chk_write_quiet: assert property (np_tx_written_q |-> mdio_oe_n && $past(mdio_oe_n, 2))
        else $error("write during device drive");
endmodule // anpr_regs_checker
bind anpr_regs_top anpr_regs_checker anpr_regs_checker_i (.mclk(mclk), .reset(reset), .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n), .tx_toggle(tx_toggle), .np_tx_word_q(np_tx_word_q), .np_tx_written_q(np_tx_written_q));
`default_nettype wire

//--- sim/anpr_sta_model.sv
/* Management controller model sending frames on mdc and data.
   Assumes the bench resolves the shared line with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
`include "anpr_regs.vh"
module anpr_sta_model (
    input wire logic mclk,
    input wire logic mdio_wire,
    output logic mdc,
    output logic sta_d,
    output logic sta_oe_n,
    output logic [15:0] rd_data,
    output logic rd_valid
);
    // ------------
    // Frame engine
    // ------------
    // Slow mdc, since the device sees it through synchronisers
    localparam int HALF = 8;
    logic smp;
    initial {mdc, sta_d, sta_oe_n, rd_valid} = 4'h6;
    task automatic put_bit(input logic b, input logic drv);
        @(negedge mclk);
        {mdc, sta_d, sta_oe_n} = {1'b0, b, !drv};
        repeat (HALF) @(negedge mclk);
        mdc = 1'b1;
        smp = mdio_wire;
        repeat (HALF - 1) @(negedge mclk);
    endtask
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
        logic [33:0] bits;
        bits = {4'hd, op, pa, ra, 2'h2, wd};
        for (int i = 33; i >= 0; i--) begin
            put_bit(bits[i], i > 17 || op == `ANPR_OP_WRITE);
            if (i < 16) rd_data[i] = smp;
        end
        @(negedge mclk);
        {mdc, sta_oe_n, rd_valid} = {2'h1, op == `ANPR_OP_READ};
        @(negedge mclk);
        rd_valid = 1'b0;
    endtask
endmodule // anpr_sta_model
`default_nettype wire

//--- sim/tb_autoneg_next_page_regs.sv
/* Bench for the next-page register group and its controller model.
   Assumes the register header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "anpr_regs.vh"
module tb_autoneg_next_page_regs;
    logic mclk, reset, mdc, mdio_in, mdio_out, mdio_oe_n, sta_d, sta_oe_n, rd_valid, pd_fault_evt, page_rx_evt;
    logic lp_np_able, lp_an_able, tx_toggle, lp_page_load, np_tx_written_q, wr_seen;
    logic [4:0] phy_addr;
    logic [15:0] lp_page, np_tx_word_q, rd_data, wd, v;
    logic [15:0] rd_q[$], wr_q[$];
    int mismatches = 0, check_count = 0;
    // Pull-up wins when nobody drives
    assign mdio_in = !mdio_oe_n ? mdio_out : (!sta_oe_n ? sta_d : 1'b1);
    anpr_regs_top anpr_regs_top_i (.mclk(mclk), .reset(reset), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n), .phy_addr(phy_addr), .pd_fault_evt(pd_fault_evt), .page_rx_evt(page_rx_evt),
        .lp_np_able(lp_np_able), .lp_an_able(lp_an_able), .tx_toggle(tx_toggle), .lp_page_load(lp_page_load),
        .lp_page(lp_page), .np_tx_word_q(np_tx_word_q), .np_tx_written_q(np_tx_written_q));
    anpr_sta_model anpr_sta_model_i (.mclk(mclk), .mdio_wire(mdio_in), .mdc(mdc), .sta_d(sta_d),
        .sta_oe_n(sta_oe_n), .rd_data(rd_data), .rd_valid(rd_valid));
    // ---------------
    // Tasks and clock
    // ---------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp);
        rd_q.push_back(exp);
        anpr_sta_model_i.frame(`ANPR_OP_READ, pa, ra, 16'h0000);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d, input logic [15:0] exp);
        if (ra == `ANPR_ADDR_NP_TX) wr_q.push_back(exp);
        anpr_sta_model_i.frame(`ANPR_OP_WRITE, phy_addr, ra, d);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        if (rd_valid === 1'b1) cmp("read", rd_q.pop_front(), rd_data);
        // Strobe leads the registered word by one cycle
        if (wr_seen === 1'b1) cmp("txword", (wr_q.size() > 0) ? wr_q.pop_front() : 16'hxxxx, np_tx_word_q);
        wr_seen <= np_tx_written_q;
    end
    initial begin
        reset = 1'b1;
        {pd_fault_evt, page_rx_evt, lp_np_able, lp_an_able, tx_toggle, lp_page_load} = 6'h00;
        lp_page = 16'h0000;
        void'($urandom(75590));
        phy_addr = 5'($urandom);
        repeat (2) @(negedge mclk);
        reset = 1'b0;
        repeat (4) @(negedge mclk);
        rd(phy_addr, `ANPR_ADDR_EXP_STATUS, `ANPR_EXP_RESET);
        rd(phy_addr, `ANPR_ADDR_NP_TX, `ANPR_NP_TX_RESET);
        rd(phy_addr, `ANPR_ADDR_LP_NP_RX, `ANPR_LP_NP_RESET);
        // A read for another station must not clear the latch
        for (int i = 0; i < 2; i++) begin
            @(negedge mclk);
            {pd_fault_evt, page_rx_evt} = (i == 0) ? 2'h2 : 2'h1;
            @(negedge mclk);
            {pd_fault_evt, page_rx_evt} = 2'h0;
            rd(phy_addr ^ 5'h01, `ANPR_ADDR_EXP_STATUS, 16'hffff);
            rd(phy_addr, `ANPR_ADDR_EXP_STATUS, (i == 0) ? 16'h0014 : 16'h0006);
            rd(phy_addr, `ANPR_ADDR_EXP_STATUS, 16'h0004);
        end
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            {lp_np_able, lp_an_able} = 2'(i);
            rd(phy_addr, `ANPR_ADDR_EXP_STATUS, {12'h000, lp_np_able, 2'h2, lp_an_able});
        end
        for (int i = 0; i < 4; i++) begin
            wd = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
            @(negedge mclk);
            tx_toggle = 1'($urandom);
            v = (wd & 16'hb7ff) | {4'h0, tx_toggle, 11'h000};
            wr(`ANPR_ADDR_NP_TX, wd, v);
            rd(phy_addr, `ANPR_ADDR_NP_TX, v);
        end
        // Unknown opcode and foreign station must leave the page alone
        anpr_sta_model_i.frame(2'h3, phy_addr, `ANPR_ADDR_NP_TX, 16'h0000);
        anpr_sta_model_i.frame(`ANPR_OP_WRITE, phy_addr ^ 5'h01, `ANPR_ADDR_NP_TX, 16'h0000);
        rd(phy_addr, `ANPR_ADDR_NP_TX, v);
        wr(`ANPR_ADDR_EXP_STATUS, 16'hffff, 16'h0000);
        wr(`ANPR_ADDR_LP_NP_RX, 16'hffff, 16'h0000);
        rd(phy_addr, `ANPR_ADDR_EXP_STATUS, 16'h000d);
        rd(phy_addr, `ANPR_ADDR_LP_NP_RX, 16'h0000);
        rd(phy_addr, 5'h09, 16'h0000);
        // Page must be captured, not shown live
        for (int i = 0; i < 3; i++) begin
            @(negedge mclk);
            {lp_page_load, lp_page} = {1'b1, (i == 0) ? 16'hffff : 16'($urandom)};
            @(negedge mclk);
            v = lp_page & 16'hbfff;
            {lp_page_load, lp_page} = {1'b0, ~lp_page};
            rd(phy_addr, `ANPR_ADDR_LP_NP_RX, v);
        end
        report_and_stop();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end
endmodule // tb_autoneg_next_page_regs
`default_nettype wire
